// file: src/ctm_pkg.sv
/*
 * ctm_pkg: register map, field positions and constants of the compact timer.
 * Assumes a 32-bit AHB-Lite slave with one register per aligned word.
 */
`default_nettype none
package ctm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMPA_LO = 8'h10;
    localparam logic [7:0] OFS_CMPA_HI = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    // first control register fields
    localparam int C0_PAUSE = 7;
    localparam int C0_CKSEL_LO = 4;
    localparam int C0_ENABLE = 3;
    localparam logic [7:0] C0_WMASK = 8'hF8;
    // second control register fields
    localparam int C1_MODE_LO = 6;
    localparam int C1_OFUNC_LO = 4;
    localparam int C1_OCTRL = 3;
    localparam int C1_POL = 2;
    localparam int C1_DPX = 1;
    localparam int C1_CCLR = 0;
    // flag register bits, write one to clear
    localparam int FLG_A = 0;
    localparam int FLG_P = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // clock select codes
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXT_R = 3'h6;
    localparam logic [2:0] CK_EXT_F = 3'h7;
    // mode codes
    localparam logic [1:0] MD_CMP = 2'h0;
    localparam logic [1:0] MD_PWM = 2'h2;
    localparam logic [1:0] MD_TMR = 2'h3;
    // output function codes
    localparam logic [1:0] OF_NONE = 2'h0;
    localparam logic [1:0] OF_LOW = 2'h1;
    localparam logic [1:0] OF_HIGH = 2'h2;
    localparam logic [1:0] OF_TOG = 2'h3;
    localparam logic [1:0] PF_INACT = 2'h0;
    localparam logic [1:0] PF_ACT = 2'h1;
    localparam logic [1:0] PF_WAVE = 2'h2;
    // prescaler divide ratios
    localparam int DIV_SYS = 4;
    localparam int DIV_H16 = 16;
    localparam int DIV_H64 = 64;
    localparam int DIV_SUB = 256;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : ctm_pkg
`default_nettype wire

// file: src/ctm_timer.sv
/*
 * ctm_timer: compact 16-bit timer with compare, PWM and timer modes behind
 * an AHB-Lite slave. Assumes one clock; slower rates come from enable pulses
 * and the external clock pin is synchronous to the clock.
 */
// How it works
// R1: pause bit set holds counter value; clearing resumes from it
// R2: three-bit clock select chooses sys/4, sys, high/16, high/64, sub or pin edges
// R3: enable rising edge zeroes the counter before counting
// R4: enable falling stops counting; counter keeps its value
// R5: enable rising edge returns pin to initial level in compare mode
// R6: mode field: 00 compare, 10 PWM, 11 timer, 01 undefined
// R7: software switches the timer off before changing mode
// R8: compare mode: output function keeps, lows, highs or toggles pin on A match
// R9: a requested level equal to the present level gives no change
// R10: PWM mode: 00 inactive, 01 active, 10 waveform, 11 undefined
// R11: software changes PWM output function only while switched off
// R12: output control sets initial level or PWM active level; none in timer mode
// R13: polarity bit inverts pin level; no effect in timer mode
// R14: duty/period bit swaps roles of period and compare A registers
// R15: clear select high clears counter on compare A match
// R16: clear select low clears on P match; overflow only when P is zero
// R17: clear select ignored in PWM mode
// R18: unused low bits of first control register read zero
// R19: counter value readable through a read-only register pair
// R20: compare A held in a read-write register pair
// R21: compare P held in one writable register
// R22: timer mode does not drive the pin
// R23: P compares counter bits 15..8; zero means full 65536 period
// R24: low-byte writes buffered until high write; high read latches low byte
// R25: outside PWM mode, clear select high raises only the A flag, never P
// R26: counter is a 16-bit up-counter checked against A on all bits
// R27: each match sets a sticky flag until software clears it, except a P match under R25
`default_nettype none
module ctm_timer #(
    parameter int CNT_W = 16,
    parameter int PER_W = 8
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_HSEL,
    input wire logic [7:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic I_FH_TICK,
    input wire logic I_FSUB_TICK,
    input wire logic I_EXT_CLK,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic O_WAVE,
    output logic O_WAVE_OE
);
    initial begin
        if (CNT_W != 16 || PER_W != 8) begin
            $error("ctm_timer supports only a 16-bit counter and 8-bit period");
        end
    end

    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [15:0] cmpa_r;
    logic [7:0] period_r;
    logic [7:0] wbuf_r;
    logic [7:0] rbuf_r;
    logic [15:0] cnt_r;
    logic [1:0] flags_r;
    logic en_d_r;
    logic out_r;
    logic ext_d_r;
    logic [7:0] div_sys_r;
    logic [7:0] div_h_r;
    logic [7:0] div_sub_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic wave_oe_r;

    // control fields
    logic pause;
    logic [2:0] cksel;
    logic enable;
    logic [1:0] mode;
    logic [1:0] ofunc;
    logic octrl;
    logic pol;
    logic dpx;
    logic cclr;
    assign pause = ctrl0_r[ctm_pkg::C0_PAUSE];
    assign cksel = ctrl0_r[ctm_pkg::C0_CKSEL_LO +: 3];
    assign enable = ctrl0_r[ctm_pkg::C0_ENABLE];
    assign mode = ctrl1_r[ctm_pkg::C1_MODE_LO +: 2];
    assign ofunc = ctrl1_r[ctm_pkg::C1_OFUNC_LO +: 2];
    assign octrl = ctrl1_r[ctm_pkg::C1_OCTRL];
    assign pol = ctrl1_r[ctm_pkg::C1_POL];
    assign dpx = ctrl1_r[ctm_pkg::C1_DPX];
    assign cclr = ctrl1_r[ctm_pkg::C1_CCLR];

    // bus address phase decode
    logic acc;
    logic rd_acc;
    assign acc = I_HSEL && I_HREADY && I_HTRANS[1];
    assign rd_acc = acc && !I_HWRITE;

    // divider tick from a free counter and a power-of-two ratio
    function automatic logic div_tick(input logic [7:0] cnt, input int ratio);
        div_tick = (cnt & 8'((ratio - 1) & 8'hFF)) == 8'((ratio - 1) & 8'hFF);
    endfunction : div_tick

    // prescaler counters on the system clock and the two external rate ticks
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            div_sys_r <= 8'h00;
            div_h_r <= 8'h00;
            div_sub_r <= 8'h00;
            ext_d_r <= 1'b0;
        end else begin
            div_sys_r <= div_sys_r + 8'h01;
            if (I_FH_TICK) begin
                div_h_r <= div_h_r + 8'h01;
            end
            if (I_FSUB_TICK) begin
                div_sub_r <= div_sub_r + 8'h01;
            end
            ext_d_r <= I_EXT_CLK;
        end
    end

    // counter clock enable selection
    logic tick;
    always_comb begin
        unique case (cksel) // see R2
            ctm_pkg::CK_SYS4: tick = div_tick(div_sys_r, ctm_pkg::DIV_SYS);
            ctm_pkg::CK_SYS: tick = 1'b1;
            ctm_pkg::CK_H16: tick = I_FH_TICK && div_tick(div_h_r, ctm_pkg::DIV_H16);
            ctm_pkg::CK_H64: tick = I_FH_TICK && div_tick(div_h_r, ctm_pkg::DIV_H64);
            ctm_pkg::CK_SUB0, ctm_pkg::CK_SUB1: tick = I_FSUB_TICK;
            ctm_pkg::CK_EXT_R: tick = I_EXT_CLK && !ext_d_r;
            ctm_pkg::CK_EXT_F: tick = !I_EXT_CLK && ext_d_r;
        endcase
    end

    // comparators and clear choice
    logic run;
    logic en_rise;
    logic match_a;
    logic match_p;
    logic ovf;
    logic clr_cnt;
    logic is_pwm;
    assign en_rise = enable && !en_d_r;
    assign run = enable && !pause && tick && !en_rise; // see R1, R4
    assign match_a = run && (cnt_r + 16'h0001) == cmpa_r && cmpa_r != 16'h0000; // see R26
    assign match_p = run && period_r != 8'h00
        && (cnt_r + 16'h0001) == {period_r, 8'h00}; // see R23
    assign ovf = run && cnt_r == 16'hFFFF;
    assign is_pwm = mode == ctm_pkg::MD_PWM;
    always_comb begin
        if (is_pwm) begin // see R17
            clr_cnt = dpx ? match_a : (match_p || (period_r == 8'h00 && ovf)); // see R14
        end else if (cclr) begin
            clr_cnt = match_a; // see R15
        end else begin
            clr_cnt = match_p || (period_r == 8'h00 && ovf); // see R16
        end
    end

    // enable edge memory
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= enable;
        end
    end

    // main up-counter
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            cnt_r <= 16'h0000;
        end else if (en_rise) begin
            cnt_r <= 16'h0000; // see R3
        end else if (run) begin
            cnt_r <= clr_cnt ? 16'h0000 : cnt_r + 16'h0001; // see R26
        end
    end

    // pwm duty compare: active while the counter is below the duty value
    logic pwm_act;
    always_comb begin
        if (dpx) begin
            pwm_act = cnt_r[15:8] < period_r; // see R14
        end else begin
            pwm_act = cnt_r < cmpa_r;
        end
    end

    // compare-mode pin state, reset to initial level on enable rise
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            out_r <= 1'b0;
        end else if (en_rise) begin
            out_r <= octrl; // see R5, R12
        end else if (match_a && mode == ctm_pkg::MD_CMP) begin
            unique case (ofunc) // see R8, R9
                ctm_pkg::OF_NONE: out_r <= out_r;
                ctm_pkg::OF_LOW: out_r <= 1'b0;
                ctm_pkg::OF_HIGH: out_r <= 1'b1;
                ctm_pkg::OF_TOG: out_r <= !out_r;
            endcase
        end
    end

    // pin level with polarity; timer mode leaves the pin undriven
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_WAVE <= 1'b0;
            wave_oe_r <= 1'b0;
        end else begin
            wave_oe_r <= mode == ctm_pkg::MD_CMP || is_pwm; // see R22
            if (is_pwm) begin
                unique case (ofunc) // see R10
                    ctm_pkg::PF_INACT: O_WAVE <= !octrl ^ pol;
                    ctm_pkg::PF_ACT: O_WAVE <= octrl ^ pol;
                    ctm_pkg::PF_WAVE: O_WAVE <= (pwm_act ? octrl : !octrl) ^ pol; // see R12, R13
                    default: O_WAVE <= !octrl ^ pol;
                endcase
            end else if (mode == ctm_pkg::MD_CMP) begin
                O_WAVE <= out_r ^ pol; // see R13
            end else begin
                O_WAVE <= 1'b0;
            end
        end
    end
    assign O_WAVE_OE = wave_oe_r;

    // delayed write phase bookkeeping
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= acc && I_HWRITE;
            wr_addr_r <= I_HADDR;
        end
    end

    // register writes in the data phase
    logic [7:0] wd;
    assign wd = I_HWDATA[7:0];
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ctrl0_r <= ctm_pkg::RST_BYTE;
            ctrl1_r <= ctm_pkg::RST_BYTE;
            cmpa_r <= 16'h0000;
            period_r <= ctm_pkg::RST_BYTE;
            wbuf_r <= ctm_pkg::RST_BYTE;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                ctm_pkg::OFS_CTRL0: ctrl0_r <= wd & ctm_pkg::C0_WMASK; // see R18
                ctm_pkg::OFS_CTRL1: ctrl1_r <= wd; // see R6
                ctm_pkg::OFS_CMPA_LO: wbuf_r <= wd; // see R24
                ctm_pkg::OFS_CMPA_HI: cmpa_r <= {wd, wbuf_r}; // see R20, R24
                ctm_pkg::OFS_PERIOD: period_r <= wd; // see R21
                default: ;
            endcase
        end
    end

    // match flags: set wins over a same-cycle clear
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            flags_r <= 2'b00;
        end else begin
            if (match_a) begin
                flags_r[ctm_pkg::FLG_A] <= 1'b1; // see R27
            end else if (wr_pend_r && wr_addr_r == ctm_pkg::OFS_FLAGS && wd[ctm_pkg::FLG_A]) begin
                flags_r[ctm_pkg::FLG_A] <= 1'b0;
            end
            if (match_p && !(cclr && !is_pwm)) begin
                flags_r[ctm_pkg::FLG_P] <= 1'b1; // see R25, R27
            end else if (wr_pend_r && wr_addr_r == ctm_pkg::OFS_FLAGS && wd[ctm_pkg::FLG_P]) begin
                flags_r[ctm_pkg::FLG_P] <= 1'b0;
            end
        end
    end

    // read data: high-byte reads latch the low byte into the read buffer
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            hrdata_r <= 32'h0000_0000;
            rbuf_r <= ctm_pkg::RST_BYTE;
        end else if (rd_acc) begin
            unique case (I_HADDR)
                ctm_pkg::OFS_CTRL0: hrdata_r <= {24'h000000, ctrl0_r}; // see R18
                ctm_pkg::OFS_CTRL1: hrdata_r <= {24'h000000, ctrl1_r};
                ctm_pkg::OFS_CNT_HI: begin
                    hrdata_r <= {24'h000000, cnt_r[15:8]}; // see R19
                    rbuf_r <= cnt_r[7:0]; // see R24
                end
                ctm_pkg::OFS_CMPA_HI: begin
                    hrdata_r <= {24'h000000, cmpa_r[15:8]};
                    rbuf_r <= cmpa_r[7:0];
                end
                ctm_pkg::OFS_CNT_LO, ctm_pkg::OFS_CMPA_LO: hrdata_r <= {24'h000000, rbuf_r};
                ctm_pkg::OFS_PERIOD: hrdata_r <= {24'h000000, period_r};
                ctm_pkg::OFS_FLAGS: hrdata_r <= {30'h00000000, flags_r};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign O_HRDATA = hrdata_r;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
endmodule : ctm_timer
`default_nettype wire

// file: testbench/ctm_pin_model.sv
/* ctm_pin_model: far side of the timer pins, an external clock source and the pin wire.
   Assumes the bench calls pulses() right after a rising clock edge. */
`default_nettype none
module ctm_pin_model (
    input wire logic i_clk,
    input wire logic i_wave,
    input wire logic i_wave_oe,
    output logic o_ext_clk,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wander_r = 1'b0;
    // an undriven pin wanders every cycle, so a stale level never passes
    always @(posedge i_clk) begin
        wander_r <= ~wander_r;
    end
    assign o_pin = i_wave_oe ? i_wave : wander_r;
    initial o_ext_clk = 1'b0;
    // bursts of clock pulses; the source stands low between bursts
    task automatic pulses(input int n);
        repeat (n) begin
            o_ext_clk <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_ext_clk <= 1'b0;
            repeat (2) @(posedge i_clk);
        end
    endtask : pulses
endmodule : ctm_pin_model
`default_nettype wire

// file: testbench/ctm_timer_chk.sv
/* ctm_timer_chk: port-level assertions on the timer, bound into ctm_timer.
   Assumes zero-wait bus answers and registered pin outputs. */
`default_nettype none
module ctm_timer_chk (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_HSEL,
    input wire logic [7:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic O_WAVE,
    input wire logic O_WAVE_OE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    logic wr_r, rd_r, take, en, oc, pol;
    logic [7:0] adr_r, c0_r, c1_r;
    logic [1:0] md, fn;
    assign take = I_HSEL & I_HREADY & I_HTRANS[1];
    assign {md, fn, oc, pol} = c1_r[7:2];
    assign en = c0_r[ctm_pkg::C0_ENABLE];
    // address of the transfer now in its data phase
    always_ff @(posedge I_CLK) begin
        if (take) adr_r <= I_HADDR;
    end
    // mirror of both control registers, updated as the data phase ends
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            c0_r <= 8'h00;
            c1_r <= 8'h00;
        end else begin
            wr_r <= take & I_HWRITE;
            rd_r <= take & ~I_HWRITE;
            if (wr_r && adr_r == ctm_pkg::OFS_CTRL0) c0_r <= I_HWDATA[7:0];
            if (wr_r && adr_r == ctm_pkg::OFS_CTRL1) c1_r <= I_HWDATA[7:0];
        end
    end
    ready_okay_a: assert property (O_HREADYOUT && !O_HRESP) else $error("bus not ready or okay");
    ctl0_zero_a: assert property (rd_r && adr_r == ctm_pkg::OFS_CTRL0 |-> O_HRDATA[2:0] == 3'h0)
        else $error("control low bits not zero");
    ctl1_back_a: assert property (rd_r && adr_r == ctm_pkg::OFS_CTRL1 |-> O_HRDATA == {24'h0, c1_r})
        else $error("second control readback wrong");
    tmr_oe_off_a: assert property (md == ctm_pkg::MD_TMR |=> !O_WAVE_OE)
        else $error("pin driven in timer mode");
    cmp_oe_on_a: assert property (md == ctm_pkg::MD_CMP |=> O_WAVE_OE)
        else $error("pin not driven in compare mode");
    en_rise_init_a: assert property (md == ctm_pkg::MD_CMP && $rose(en) |-> ##[1:2] O_WAVE == (oc ^ pol))
        else $error("pin not at initial level");
    pin_hold_a: assert property ((md == ctm_pkg::MD_CMP && fn == ctm_pkg::OF_NONE && en) [*4] |-> $stable(O_WAVE))
        else $error("pin moved with no change selected");
    pwm_inact_a: assert property ((md == ctm_pkg::MD_PWM && fn == ctm_pkg::PF_INACT && en) [*4] |-> O_WAVE == (~oc ^ pol))
        else $error("forced inactive level wrong");
    pwm_act_a: assert property ((md == ctm_pkg::MD_PWM && fn == ctm_pkg::PF_ACT && en) [*4] |-> O_WAVE == (oc ^ pol))
        else $error("forced active level wrong");
endmodule : ctm_timer_chk
bind ctm_timer ctm_timer_chk i_chk (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA),
    .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .O_WAVE(O_WAVE), .O_WAVE_OE(O_WAVE_OE));
`default_nettype wire

// file: testbench/ctm_timer_bench.sv
/* ctm_timer_bench: self-checking run of the timer over its register bus and pins.
   Assumes the package, the timer, its checker and the pin model are compiled first. */
`default_nettype none
module ctm_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0, pin_req = 1'b0;
    logic sub_tick = 1'b0;
    logic fh_tick = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [2:0] sub_div = 3'h0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic hready, hresp, wave, wave_oe, ext_clk, pin;
    logic [31:0] exp_q[$];
    int tol_q[$];
    int fails = 0, total_checks = 0, seed = 72;
    ctm_timer i_dut (.I_CLK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(hready), .I_FH_TICK(fh_tick), .I_FSUB_TICK(sub_tick), .I_EXT_CLK(ext_clk),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_WAVE(wave),
        .O_WAVE_OE(wave_oe));
    ctm_pin_model i_pm (.i_clk(clk), .i_wave(wave), .i_wave_oe(wave_oe), .o_ext_clk(ext_clk),
        .o_pin(pin));
    initial forever #2 clk = ~clk;
    // sub-clock tick once every eight cycles, high-clock tick every other cycle
    always @(posedge clk) begin
        fh_tick <= ~fh_tick;
        sub_div <= sub_div + 3'h1;
        sub_tick <= (sub_div == 3'h7);
    end
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fails++;
                end_of_test;
            end
            @(posedge clk);
        end
    endtask : wait_rdy
    // one single word transfer; a read with t >= 0 leaves a note for the watcher
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input int t, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= ctm_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w && t >= 0) begin
            exp_q.push_back(e);
            tol_q.push_back(t);
            rd_dp <= 1'b1;
        end
        wait_rdy;
        q = hrdata;
        rd_dp <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, 32'h0, -1, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input int t);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, e, t, q);
    endtask : rd
    // poll the flags until bit b shows, within a bound
    task automatic wait_flag(input int b);
        logic [31:0] q;
        q = 32'h0;
        for (int n = 0; q[b] !== 1'b1; n++) begin
            if (n > 400) begin
                fails++;
                end_of_test;
            end
            xfer(1'b0, ctm_pkg::OFS_FLAGS, 32'h0, 32'h0, -1, q);
        end
    endtask : wait_flag
    task automatic pin_chk(input logic e);
        exp_q.push_back({31'h0, e});
        tol_q.push_back(0);
        pin_req <= 1'b1;
        @(posedge clk);
        pin_req <= 1'b0;
    endtask : pin_chk
    // take the oldest note whenever read data or a pin sample is due
    always @(posedge clk) begin
        logic [31:0] s, e;
        int t;
        if (rd_dp || pin_req) begin
            s = rd_dp ? hrdata : {31'h0, pin};
            e = exp_q.pop_front();
            t = tol_q.pop_front();
            total_checks++;
            if ((s + t >= e && s <= e + t) !== 1'b1) begin
                fails++;
                $display("unexpected %s: expected %0h seen %0h", rd_dp ? "data" : "pin", e, s);
            end
        end
    end
    // main sequence: registers, clock sources, compare, PWM and timer modes
    initial begin
        logic [31:0] v;
        logic [1:0] f;
        int cnt_exp[6];
        cnt_exp = '{50, 200, 6, 2, 25, 25};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(ctm_pkg::OFS_CTRL1, 32'h0, 0);
        wr(ctm_pkg::OFS_CTRL0, 32'h77);
        rd(ctm_pkg::OFS_CTRL0, 32'h70, 0);
        wr(ctm_pkg::OFS_CNT_HI, 32'hFF);
        rd(ctm_pkg::OFS_CNT_HI, 32'h0, 0);
        v = $random(seed);
        wr(ctm_pkg::OFS_CMPA_LO, {24'h0, v[7:0]});
        wr(ctm_pkg::OFS_CMPA_HI, {24'h0, v[15:8]});
        wr(ctm_pkg::OFS_PERIOD, {24'h0, v[23:16]});
        wr(ctm_pkg::OFS_CMPA_LO, {24'h0, ~v[7:0]});
        rd(ctm_pkg::OFS_CMPA_HI, {24'h0, v[15:8]}, 0);
        rd(ctm_pkg::OFS_CMPA_LO, {24'h0, v[7:0]}, 0);
        rd(ctm_pkg::OFS_PERIOD, {24'h0, v[23:16]}, 0);
        wr(8'h40, 32'hFF);
        rd(8'h40, 32'h0, 0);
        for (int c = 0; c < 6; c++) begin
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(c), 4'h8});
            repeat (200) @(posedge clk);
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(c), 4'h0});
            rd(ctm_pkg::OFS_CNT_HI, 32'h0, 0);
            rd(ctm_pkg::OFS_CNT_LO, 32'(cnt_exp[c]), 3);
        end
        for (int c = 6; c < 8; c++) begin
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(c), 4'h8});
            // the enable edge cycle zeroes the counter and takes no count
            @(posedge clk);
            i_pm.pulses(3);
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b1, 3'(c), 4'h8});
            i_pm.pulses(3);
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(c), 4'h8});
            i_pm.pulses(2);
            repeat (4) @(posedge clk);
            wr(ctm_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(c), 4'h0});
            i_pm.pulses(2);
            rd(ctm_pkg::OFS_CNT_HI, 32'h0, 0);
            rd(ctm_pkg::OFS_CNT_LO, 32'h5, 0);
        end
        wr(ctm_pkg::OFS_CTRL0, 32'h68);
        @(posedge clk);
        rd(ctm_pkg::OFS_CNT_HI, 32'h0, 0);
        rd(ctm_pkg::OFS_CNT_LO, 32'h0, 0);
        wr(ctm_pkg::OFS_CTRL0, 32'h60);
        wr(ctm_pkg::OFS_CMPA_LO, 32'h30);
        wr(ctm_pkg::OFS_CMPA_HI, 32'h0);
        for (int k = 0; k < 8; k++) begin
            f = 2'(k);
            wr(ctm_pkg::OFS_CTRL1, {24'h0, 2'h0, f, 1'b0, k[2], 2'h1});
            wr(ctm_pkg::OFS_FLAGS, 32'h3);
            wr(ctm_pkg::OFS_CTRL0, 32'h18);
            wait_flag(ctm_pkg::FLG_A);
            pin_chk((f == ctm_pkg::OF_HIGH || f == ctm_pkg::OF_TOG) ^ k[2]);
            rd(ctm_pkg::OFS_FLAGS, 32'h1, 0);
            wr(ctm_pkg::OFS_CTRL0, 32'h10);
            wr(ctm_pkg::OFS_FLAGS, 32'h3);
            rd(ctm_pkg::OFS_FLAGS, 32'h0, 0);
        end
        wr(ctm_pkg::OFS_PERIOD, 32'h1);
        wr(ctm_pkg::OFS_CTRL1, 32'h0);
        wr(ctm_pkg::OFS_CTRL0, 32'h18);
        wait_flag(ctm_pkg::FLG_P);
        rd(ctm_pkg::OFS_CNT_HI, 32'h0, 0);
        rd(ctm_pkg::OFS_FLAGS, 32'h3, 0);
        wr(ctm_pkg::OFS_CTRL0, 32'h10);
        for (int k = 0; k < 8; k++) begin
            v = {24'h0, ctm_pkg::MD_PWM, 1'b0, k[0], k[1], k[2], 2'h0};
            wr(ctm_pkg::OFS_CTRL1, v);
            wr(ctm_pkg::OFS_CTRL0, 32'h18);
            rd(ctm_pkg::OFS_CTRL1, v, 0);
            pin_chk((k[0] ? k[1] : ~k[1]) ^ k[2]);
            wr(ctm_pkg::OFS_CTRL0, 32'h10);
        end
        // pwm waveform, active high: active early in the period, inactive late in it
        for (int d = 0; d < 2; d++) begin
            wr(ctm_pkg::OFS_CMPA_LO, 32'h80);
            wr(ctm_pkg::OFS_CMPA_HI, {31'h0, d[0]});
            wr(ctm_pkg::OFS_CTRL1, {24'h0, ctm_pkg::MD_PWM, ctm_pkg::PF_WAVE, 2'h2, d[0], 1'b0});
            wr(ctm_pkg::OFS_FLAGS, 32'h3);
            wr(ctm_pkg::OFS_CTRL0, 32'h18);
            wait_flag(d[0] ? ctm_pkg::FLG_A : ctm_pkg::FLG_P);
            pin_chk(1'b1);
            repeat (d[0] ? 300 : 160) @(posedge clk);
            pin_chk(1'b0);
            wr(ctm_pkg::OFS_CTRL0, 32'h10);
        end
        wr(ctm_pkg::OFS_CTRL1, 32'hC1);
        wr(ctm_pkg::OFS_FLAGS, 32'h3);
        wr(ctm_pkg::OFS_CTRL0, 32'h18);
        wait_flag(ctm_pkg::FLG_A);
        end_of_test;
    end
endmodule : ctm_timer_bench
`default_nettype wire
